/* core/bcs_bridge_regs.sv */
// configuration, supply monitor and diagnostics registers of the bridge driver
// How it works
// (RQ1) config bit 7: 1 full bridge, 0 two single stages for levels 1 to 3 only
// (RQ2) config bit 6 at 1: outputs follow parallel pins, at 0 the drive bits
// (RQ3) under register control bit 5 drives first output, bit 4 the second
// (RQ4) config bits 3:2 give current level 1 to 4, level 3 default
// (RQ5) writing 0 to config bit 1 resets config, supply monitor and diagnostics
// (RQ6) config resets to 0xfa; bit 0 high selects slow slew
// (RQ7) while stage disabled, bits 6, 5, 4 and 1 are forced to 1
// (RQ8) supply monitor bit 7 low enters threshold test mode
// (RQ9) in test mode bit 6 high raises lower threshold, low lowers upper one
// (RQ10) supply monitor bit 5 chooses latched or live overvoltage report
// (RQ11) writing 0 to bit 4 or 3 clears second or first output diagnosis; read as 1
// (RQ12) supply monitor bit 2 returns the bridge enable pin level
// (RQ13) supply monitor bit 1 low while supply under its lower limit
// (RQ14) supply monitor bit 0 low on supply overvoltage
// (RQ15) power-up, register reset, flag mode restore supply monitor bits 7:3 to 11011
// (RQ16) power-up, register reset, enable edge set diagnostics 6:0; bit 7 live
// (RQ17) reading diagnostics sets bits 6:4 to 1, per-output bits kept
// (RQ18) identifier and revision never change on any reset
// (RQ19) output supply pin held low restores config and supply monitor resets
// (RQ20) unlisted reset sources leave a register unchanged
// (RQ21) diagnostics bit 7 reads 0 whenever either input disables the stages
// (RQ22) the logic-reset bit returns to 1 by itself after the reset
`timescale 1ns/1ps
module bcs_bridge_regs
   import bcs_pkg::*;
#(
   parameter logic [7:0] DEVICE_ID = 8'h5a,   // arbitrary value
   parameter logic [7:0] DEVICE_REV = 8'h11   // arbitrary value
) (
   // clock and power-up reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // decoded register access from the serial frame logic
   input wire bcs_req_t req_i,
   output logic [7:0] rd_data_o,
   output logic rd_valid_o,
   // asynchronous pins and sensor levels
   input wire bcs_pins_t pins_i,
   // power stage controls
   output logic first_output_o,
   output logic second_output_o,
   output logic bridge_mode_o,
   output logic [1:0] current_level_o,
   output logic slew_slow_o,
   output logic stage_enable_o,
   // supply monitor controls and status
   output logic raise_lower_threshold_o,
   output logic lower_upper_threshold_o,
   output logic supply_fault_o
);

   // synchronised pin levels
   bcs_pins_t pins_s;
   logic [BCS_PINS_W-1:0] pins_sync;

   // register state
   logic [7:0] cfg_q;
   logic [7:0] cfg_d;
   logic [2:0] st_ctrl_q;
   logic [2:0] st_ctrl_d;
   logic [6:0] diag_q;
   logic [6:0] diag_d;
   logic ov_latched_q;
   logic ov_latched_d;
   logic stage_en_q;

   // output registers
   logic [7:0] rd_data_q;
   logic rd_valid_q;
   logic first_out_q;
   logic second_out_q;
   logic bridge_mode_q;
   logic [1:0] current_level_q;
   logic slew_slow_q;
   logic stage_enable_q;
   logic raise_lower_q;
   logic lower_upper_q;
   logic supply_fault_q;

   // pins cross into clock_i before anything reads them
   bcs_sync #(
      .WIDTH(BCS_PINS_W),
      .RST_VAL('0)
   ) u_pin_sync (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .async_i(pins_i),
      .sync_o(pins_sync)
   );

   assign pins_s = bcs_pins_t'(pins_sync);

   // access decode shared by write and read paths
   function automatic logic hit(input bcs_req_t r, input bcs_sel_t s, input logic is_wr);
      hit = (r.sel == s) && (is_wr ? r.wr : r.rd);
   endfunction

   wire wr_cfg = hit(req_i, BCS_SEL_CFG, 1'b1);
   wire wr_stat = hit(req_i, BCS_SEL_STAT, 1'b1);
   wire rd_diag = hit(req_i, BCS_SEL_DIAG, 1'b0);
   wire rd_stat = hit(req_i, BCS_SEL_STAT, 1'b0);

   // stage status and reset sources
   wire stage_enabled = pins_s.bridge_enable_pin & ~pins_s.disable_pin;  // (RQ21)
   wire enable_edge_reset = stage_enabled ^ stage_en_q;
   wire disabled_level_reset = ~stage_enabled;
   wire flag_mode_reset = pins_s.output_supply_low;                     // (RQ19)
   wire register_triggered_reset = wr_cfg & ~req_i.wdata[CFG_RESET_BIT];  // (RQ5)
   wire cfg_restore = register_triggered_reset | flag_mode_reset;      // (RQ5) (RQ19)
   wire clr_first = wr_stat & ~req_i.wdata[ST_CLR1_BIT];               // (RQ11)
   wire clr_second = wr_stat & ~req_i.wdata[ST_CLR2_BIT];              // (RQ11)

   // configuration: write, then restore, then the disabled-stage forcing on top
   wire [7:0] cfg_written = wr_cfg ? req_i.wdata : cfg_q;
   wire [7:0] cfg_base = cfg_restore ? CFG_RST_VAL : cfg_written;      // (RQ6)
   assign cfg_d = disabled_level_reset ? (cfg_base | CFG_DIS_FORCE) : cfg_base;  // (RQ7)

   // writable supply monitor bits; clear bits are not stored, they always read 1
   wire [2:0] st_written = wr_stat ? req_i.wdata[ST_TEST_DIS_BIT:ST_OV_LATCH_BIT] : st_ctrl_q;
   assign st_ctrl_d = cfg_restore ? ST_CTRL_RST_VAL : st_written;      // (RQ15)

   // decoded supply monitor controls
   wire test_mode = ~st_ctrl_q[2];                                      // (RQ8)
   wire test_dir = st_ctrl_q[1];
   wire ov_latch_en = st_ctrl_q[0];                                     // (RQ10)

   // overvoltage latch; a fresh overvoltage wins over the read that clears it
   wire ov_now = pins_s.supply_over;
   wire ov_clear = rd_stat | ~ov_latch_en | cfg_restore;
   assign ov_latched_d = (ov_now & ov_latch_en) | (ov_latched_q & ~ov_clear);  // (RQ10)
   wire supply_over_flag = ~(ov_now | (ov_latched_q & ov_latch_en));   // (RQ14)
   wire supply_under_flag = ~pins_s.supply_under;                       // (RQ13)

   // diagnostics restore mask from every listed source
   wire [6:0] diag_full = (register_triggered_reset | enable_edge_reset) ? DIAG_ALL_SET : DIAG_NONE;  // (RQ16)
   wire [6:0] diag_rdr = rd_diag ? DIAG_READ_MASK : DIAG_NONE;         // (RQ17)
   wire [6:0] diag_c1 = clr_first ? DIAG_CLR1_MASK : DIAG_NONE;        // (RQ11)
   wire [6:0] diag_c2 = clr_second ? DIAG_CLR2_MASK : DIAG_NONE;       // (RQ11)
   wire [6:0] diag_restore = diag_full | diag_rdr | diag_c1 | diag_c2;

   // faults pull bits low; a fault in the clearing cycle is kept, not lost
   wire [6:0] fault_hits = {pins_s.over_temperature,
                            pins_s.thermal_reduction,
                            pins_s.current_limit,
                            pins_s.second_output_fault,
                            pins_s.first_output_fault};
   assign diag_d = (diag_q | diag_restore) & ~fault_hits;

   // read views of the diagnostics and supply monitor registers
   wire [7:0] diag_view = {stage_enabled, diag_q};                      // (RQ21)
   wire [7:0] stat_view = {st_ctrl_q,
                           ST_CLR_READBACK,                             // (RQ11)
                           pins_s.bridge_enable_pin,                    // (RQ12)
                           supply_under_flag,                           // (RQ13)
                           supply_over_flag};                           // (RQ14)

   // read selection; unknown selectors read as zero
   logic [7:0] rd_mux;
   always_comb
   begin
      unique case (req_i.sel)
         BCS_SEL_DIAG: rd_mux = diag_view;
         BCS_SEL_CFG: rd_mux = cfg_q;
         BCS_SEL_STAT: rd_mux = stat_view;
         BCS_SEL_IDENT: rd_mux = DEVICE_ID;                             // (RQ18)
         BCS_SEL_REV: rd_mux = DEVICE_REV;                              // (RQ18)
         default: rd_mux = 8'h00;
      endcase
   end

   // output stage sources
   wire par_control = cfg_q[CFG_SRC_BIT];                               // (RQ2)
   wire first_src = par_control ? pins_s.parallel_input_first : cfg_q[CFG_DRV1_BIT];    // (RQ3)
   wire second_src = par_control ? pins_s.parallel_input_second : cfg_q[CFG_DRV2_BIT];  // (RQ3)
   wire [1:0] cl_raw = {cfg_q[CFG_CL_HI_BIT], cfg_q[CFG_CL_LO_BIT]};    // (RQ4)
   wire single_stage = ~cfg_q[CFG_MODE_BIT];                            // (RQ1)
   // single stages cannot carry level 4, so it is held at level 3 there
   wire [1:0] cl_eff = (single_stage && cl_raw == CL_LEVEL4) ? CL_LEVEL3 : cl_raw;  // (RQ1)

   // register state; power-up reset sets every listed default
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cfg_q <= CFG_RST_VAL;                                          // (RQ6)
         st_ctrl_q <= ST_CTRL_RST_VAL;                                  // (RQ15)
         diag_q <= DIAG_ALL_SET;                                        // (RQ16)
         ov_latched_q <= 1'b0;
         stage_en_q <= 1'b0;
      end
      else
      begin
         cfg_q <= cfg_d;                                                // (RQ20) (RQ22)
         st_ctrl_q <= st_ctrl_d;
         diag_q <= diag_d;
         ov_latched_q <= ov_latched_d;
         stage_en_q <= stage_enabled;
      end
   end

   // read answer registered one clock after the request
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rd_data_q <= 8'h00;
         rd_valid_q <= 1'b0;
      end
      else
      begin
         rd_data_q <= req_i.rd ? rd_mux : rd_data_q;
         rd_valid_q <= req_i.rd;
      end
   end

   // power stage and monitor controls, registered so outputs are glitch free
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         first_out_q <= 1'b0;
         second_out_q <= 1'b0;
         bridge_mode_q <= 1'b1;
         current_level_q <= CL_LEVEL3;
         slew_slow_q <= 1'b0;
         stage_enable_q <= 1'b0;
         raise_lower_q <= 1'b0;
         lower_upper_q <= 1'b0;
         supply_fault_q <= 1'b0;
      end
      else
      begin
         first_out_q <= first_src;
         second_out_q <= second_src;
         bridge_mode_q <= cfg_q[CFG_MODE_BIT];                          // (RQ1)
         current_level_q <= cl_eff;
         slew_slow_q <= cfg_q[CFG_SLEW_BIT];                            // (RQ6)
         stage_enable_q <= stage_enabled;
         raise_lower_q <= test_mode & test_dir;                         // (RQ9)
         lower_upper_q <= test_mode & ~test_dir;                        // (RQ9)
         supply_fault_q <= ~(supply_under_flag & supply_over_flag);
      end
   end

   // ports
   assign rd_data_o = rd_data_q;
   assign rd_valid_o = rd_valid_q;
   assign first_output_o = first_out_q;
   assign second_output_o = second_out_q;
   assign bridge_mode_o = bridge_mode_q;
   assign current_level_o = current_level_q;
   assign slew_slow_o = slew_slow_q;
   assign stage_enable_o = stage_enable_q;
   assign raise_lower_threshold_o = raise_lower_q;
   assign lower_upper_threshold_o = lower_upper_q;
   assign supply_fault_o = supply_fault_q;

endmodule // bcs_bridge_regs

/* core/bcs_pkg.sv */
// shared constants and types for the bridge configuration and status registers
package bcs_pkg;

   // register selector carried with every access from the serial frame decoder
   typedef enum logic [2:0] {
      BCS_SEL_DIAG = 3'h0,
      BCS_SEL_CFG = 3'h1,
      BCS_SEL_STAT = 3'h2,
      BCS_SEL_IDENT = 3'h3,
      BCS_SEL_REV = 3'h4
   } bcs_sel_t;

   // one decoded register access, valid for a single clock
   typedef struct packed {
      logic rd;
      logic wr;
      bcs_sel_t sel;
      logic [7:0] wdata;
   } bcs_req_t;

   // raw pin and sensor levels, all asynchronous to clock_i
   typedef struct packed {
      logic bridge_enable_pin;
      logic disable_pin;
      logic parallel_input_first;
      logic parallel_input_second;
      logic output_supply_low;
      logic supply_under;
      logic supply_over;
      logic over_temperature;
      logic thermal_reduction;
      logic current_limit;
      logic [1:0] second_output_fault;
      logic [1:0] first_output_fault;
   } bcs_pins_t;

   localparam int unsigned BCS_PINS_W = $bits(bcs_pins_t);

   // configuration register field positions
   localparam int unsigned CFG_MODE_BIT = 7;
   localparam int unsigned CFG_SRC_BIT = 6;
   localparam int unsigned CFG_DRV1_BIT = 5;
   localparam int unsigned CFG_DRV2_BIT = 4;
   localparam int unsigned CFG_CL_HI_BIT = 3;
   localparam int unsigned CFG_CL_LO_BIT = 2;
   localparam int unsigned CFG_RESET_BIT = 1;
   localparam int unsigned CFG_SLEW_BIT = 0;
   localparam logic [7:0] CFG_RST_VAL = 8'hfa;
   localparam logic [7:0] CFG_DIS_FORCE = 8'h72;

   // current levels
   localparam logic [1:0] CL_LEVEL4 = 2'h3;
   localparam logic [1:0] CL_LEVEL3 = 2'h2;

   // supply monitor register field positions
   localparam int unsigned ST_TEST_DIS_BIT = 7;
   localparam int unsigned ST_TEST_DIR_BIT = 6;
   localparam int unsigned ST_OV_LATCH_BIT = 5;
   localparam int unsigned ST_CLR2_BIT = 4;
   localparam int unsigned ST_CLR1_BIT = 3;
   localparam int unsigned ST_EN_PIN_BIT = 2;
   localparam int unsigned ST_UNDER_BIT = 1;
   localparam int unsigned ST_OVER_BIT = 0;
   localparam logic [2:0] ST_CTRL_RST_VAL = 3'h6;
   localparam logic [1:0] ST_CLR_READBACK = 2'h3;

   // diagnostics register
   localparam int unsigned DIAG_STAGE_BIT = 7;
   localparam logic [6:0] DIAG_ALL_SET = 7'h7f;
   localparam logic [6:0] DIAG_READ_MASK = 7'h70;
   localparam logic [6:0] DIAG_CLR1_MASK = 7'h03;
   localparam logic [6:0] DIAG_CLR2_MASK = 7'h0c;
   localparam logic [6:0] DIAG_NONE = 7'h00;

endpackage

/* core/bcs_sync.sv */
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module bcs_sync #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // levels
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_q;

   // first stage is read only by the second stage
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta_q <= RST_VAL;
         sync_o <= RST_VAL;
      end
      else
      begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end

endmodule // bcs_sync

/* testbench/bcs_bridge_regs_chk.sv */
// port assertions for the bridge register bank
`timescale 1ns/1ps
module bcs_bridge_regs_chk
   import bcs_pkg::*;
#(
   parameter logic [7:0] DEVICE_ID = 8'h00,
   parameter logic [7:0] DEVICE_REV = 8'h00
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // access port
   input wire bcs_req_t req_i,
   input wire logic [7:0] rd_data_o,
   input wire logic rd_valid_o,
   // pins and controls
   input wire bcs_pins_t pins_i,
   input wire logic bridge_mode_o,
   input wire logic [1:0] current_level_o,
   input wire logic slew_slow_o,
   input wire logic stage_enable_o,
   input wire logic supply_fault_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // read strobes for config, supply monitor and diagnostics, and the logic-reset write strobe
   wire rd_cfg = req_i.rd && req_i.sel == BCS_SEL_CFG;
   wire rd_stat = req_i.rd && req_i.sel == BCS_SEL_STAT;
   wire rd_diag = req_i.rd && req_i.sel == BCS_SEL_DIAG;
   wire soft_rst = req_i.wr && req_i.sel == BCS_SEL_CFG && !req_i.wdata[CFG_RESET_BIT];
   a_read_answers: assert property (req_i.rd |=> rd_valid_o) else $error("read not answered");
   a_no_stray_valid: assert property (rd_valid_o |-> $past(req_i.rd)) else $error("stray read valid");
   a_ident_kept: assert property (
      req_i.rd && req_i.sel == BCS_SEL_IDENT |=> rd_data_o == DEVICE_ID) else $error("identifier changed");
   a_rev_kept: assert property (
      req_i.rd && req_i.sel == BCS_SEL_REV |=> rd_data_o == DEVICE_REV) else $error("revision changed");
   a_reset_bit_high: assert property (rd_cfg |=> rd_data_o[CFG_RESET_BIT]) else $error("reset bit low");
   a_clear_bits_one: assert property (
      rd_stat |=> rd_data_o[4:3] == ST_CLR_READBACK) else $error("clear bits not one");
   a_soft_reset: assert property (
      soft_rst |-> ##2 bridge_mode_o && current_level_o == CL_LEVEL3 && !slew_slow_o)
      else $error("logic reset not applied");
   a_disabled_force: assert property (
      (!stage_enable_o) [*2] ##0 rd_cfg |=> (rd_data_o & CFG_DIS_FORCE) == CFG_DIS_FORCE)
      else $error("disabled bits not forced");
   // stage_enable_o lags the live level by one clock, so look one clock after the read
   a_diag_stage_bit: assert property (
      rd_diag ##1 !stage_enable_o |-> !rd_data_o[DIAG_STAGE_BIT]) else $error("stage bit high");
   a_enable_level: assert property (
      (pins_i.bridge_enable_pin) [*5] ##0 rd_stat |=> rd_data_o[ST_EN_PIN_BIT]) else $error("enable level");
   a_single_level: assert property (
      !bridge_mode_o |-> current_level_o != CL_LEVEL4) else $error("level 4 in single mode");
   a_under_fault: assert property (
      (pins_i.supply_under) [*5] |-> supply_fault_o) else $error("undervoltage not flagged");
   a_disable_pin: assert property (
      (pins_i.disable_pin) [*4] |-> !stage_enable_o) else $error("stage still enabled");
   // main scenarios reached
   c_soft_reset: cover property (soft_rst);
   c_disabled_read: cover property (!stage_enable_o ##0 rd_diag);
   c_single_stage: cover property (!bridge_mode_o);
endmodule // bcs_bridge_regs_chk

bind bcs_bridge_regs bcs_bridge_regs_chk #(.DEVICE_ID(DEVICE_ID), .DEVICE_REV(DEVICE_REV)) bcs_bridge_regs_chk_inst (
   .clock_i, .rst_n_i, .req_i, .rd_data_o, .rd_valid_o, .pins_i, .bridge_mode_o,
   .current_level_o, .slew_slow_o, .stage_enable_o, .supply_fault_o);

/* testbench/bcs_master_model.sv */
// bus master model issuing decoded register strobes
`timescale 1ns/1ps
module bcs_master_model
   import bcs_pkg::*;
(
   // clock
   input wire logic clock_i,
   // decoded access towards the registers
   output bcs_req_t req_o
);
   initial req_o = '0;
   // one strobe per access, seen at exactly one sampling edge
   task automatic access(input logic rd, input logic wr, input bcs_sel_t sel, input logic [7:0] d);
      @(posedge clock_i);
      req_o <= '{rd: rd, wr: wr, sel: sel, wdata: d};
      @(posedge clock_i);
      req_o <= '0;
   endtask
endmodule // bcs_master_model

/* testbench/testbench.sv */
// self-checking bench for the bridge register bank
`timescale 1ns/1ps
module testbench;
   import bcs_pkg::*;
   localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary value
   localparam logic [7:0] REV_VAL = 8'h21; // arbitrary value
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   bcs_req_t req;
   bcs_pins_t pins;
   logic [7:0] rd_data, r, d;
   logic rd_valid, first_output, second_output, mode, slew, sten, thr_up, thr_dn, sfault;
   logic [1:0] level;
   logic [7:0] expq[$];
   int miscompares = 0;
   int checks = 0;
   always #2.5 clock_i = ~clock_i;
   bcs_master_model bcs_master_model_inst (.clock_i, .req_o(req));
   bcs_bridge_regs #(.DEVICE_ID(ID_VAL), .DEVICE_REV(REV_VAL)) bcs_bridge_regs_inst (
      .clock_i, .rst_n_i, .req_i(req), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .pins_i(pins),
      .first_output_o(first_output), .second_output_o(second_output), .bridge_mode_o(mode), .current_level_o(level),
      .slew_slow_o(slew), .stage_enable_o(sten), .raise_lower_threshold_o(thr_up),
      .lower_upper_threshold_o(thr_dn), .supply_fault_o(sfault));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic conclude();
      if (expq.size() != 0)
      begin
         miscompares++;
         $display("unexpected pending reads expected 0 seen %0d", expq.size());
      end
      if (miscompares == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // note the expected data, then let the master read
   task automatic rd(input bcs_sel_t s, input logic [7:0] e);
      expq.push_back(e);
      bcs_master_model_inst.access(1'b1, 1'b0, s, 8'h00);
   endtask
   task automatic wr(input bcs_sel_t s, input logic [7:0] v);
      bcs_master_model_inst.access(1'b0, 1'b1, s, v);
   endtask
   // pins cross two sync flops plus a register
   task automatic pin_wait();
      repeat (6) @(posedge clock_i);
   endtask
   // outputs packed as mode, first_output, second_output, level, slew, stage enable, supply fault
   // outputs lag the register by one clock; return on a rising edge for the next drive
   task automatic lv(input logic [7:0] e);
      @(posedge clock_i);
      @(negedge clock_i);
      chk("outputs", e, {mode, first_output, second_output, level, slew, sten, sfault});
      @(posedge clock_i);
   endtask
   task automatic thr(input logic [1:0] e);
      @(posedge clock_i);
      @(negedge clock_i);
      chk("thresholds", {6'h00, e}, {6'h00, thr_up, thr_dn});
      @(posedge clock_i);
   endtask
   // read monitor takes the oldest note for every answer, mid-cycle while valid stands
   always @(negedge clock_i)
      if (rd_valid === 1'b1)
         chk("read data", expq.size() != 0 ? expq.pop_front() : 8'hxx, rd_data);
   initial
   begin
      repeat (5000) @(posedge clock_i);
      $display("unexpected timeout expected 0 seen 1");
      miscompares++;
      conclude();
   end
   initial
   begin
      pins = '0;
      pins.bridge_enable_pin = 1'b1;
      r = $urandom(92014);
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1'b1;
      pin_wait();
      lv(8'h92);
      rd(BCS_SEL_CFG, 8'hfa);
      rd(BCS_SEL_STAT, 8'hdf);
      rd(BCS_SEL_DIAG, 8'hff);
      rd(BCS_SEL_IDENT, ID_VAL);
      rd(BCS_SEL_REV, REV_VAL);
      rd(bcs_sel_t'(3'h5), 8'h00);
      wr(BCS_SEL_IDENT, 8'h00);
      rd(BCS_SEL_IDENT, ID_VAL);
      // parallel pin control
      pins.parallel_input_first <= 1'b1;
      pins.parallel_input_second <= 1'b1;
      pin_wait();
      lv(8'hf2);
      // register control across every current level
      for (int i = 0; i < 4; i++)
      begin
         r = $urandom();
         d = {2'b00, r[1:0], i[1:0], 1'b1, r[2]};
         d[7] = 1'b1;
         wr(BCS_SEL_CFG, d);
         rd(BCS_SEL_CFG, d);
         lv({1'b1, r[1:0], i[1:0], r[2], 2'b10});
      end
      wr(BCS_SEL_CFG, 8'h3e);
      rd(BCS_SEL_CFG, 8'h3e);
      lv(8'h72);
      // threshold test modes, then a logic reset
      wr(BCS_SEL_STAT, 8'h58);
      thr(2'b10);
      wr(BCS_SEL_STAT, 8'h38);
      rd(BCS_SEL_STAT, 8'h3f);
      thr(2'b01);
      wr(BCS_SEL_CFG, 8'h0c);
      rd(BCS_SEL_CFG, 8'hfa);
      rd(BCS_SEL_STAT, 8'hdf);
      thr(2'b00);
      // latched faults, read clear and per-output clears
      pins.first_output_fault <= 2'b11;
      pins.second_output_fault <= 2'b01;
      pins.over_temperature <= 1'b1;
      pins.thermal_reduction <= 1'b1;
      pins.current_limit <= 1'b1;
      pin_wait();
      pins.first_output_fault <= 2'b00;
      pins.second_output_fault <= 2'b00;
      pins.over_temperature <= 1'b0;
      pins.thermal_reduction <= 1'b0;
      pins.current_limit <= 1'b0;
      pin_wait();
      rd(BCS_SEL_DIAG, 8'h88);
      rd(BCS_SEL_DIAG, 8'hf8);
      wr(BCS_SEL_STAT, 8'hd0);
      rd(BCS_SEL_DIAG, 8'hfb);
      wr(BCS_SEL_STAT, 8'hc8);
      rd(BCS_SEL_DIAG, 8'hff);
      // supply status bits
      pins.supply_under <= 1'b1;
      pin_wait();
      rd(BCS_SEL_STAT, 8'hdd);
      lv(8'hf3);
      pins.supply_under <= 1'b0;
      pins.supply_over <= 1'b1;
      pin_wait();
      rd(BCS_SEL_STAT, 8'hde);
      pins.supply_over <= 1'b0;
      pin_wait();
      rd(BCS_SEL_STAT, 8'hdf);
      // latched overvoltage survives its cause until the monitor is read
      wr(BCS_SEL_STAT, 8'hf8);
      pins.supply_over <= 1'b1;
      pin_wait();
      pins.supply_over <= 1'b0;
      pin_wait();
      rd(BCS_SEL_STAT, 8'hfe);
      rd(BCS_SEL_STAT, 8'hff);
      // disable level and enable edges
      wr(BCS_SEL_CFG, 8'h0e);
      pins.first_output_fault <= 2'b11;
      pin_wait();
      pins.first_output_fault <= 2'b00;
      pins.disable_pin <= 1'b1;
      pin_wait();
      rd(BCS_SEL_CFG, 8'h7e);
      rd(BCS_SEL_DIAG, 8'h7f);
      // a fault while disabled, then the enabling edge must wipe it
      pins.first_output_fault <= 2'b11;
      pin_wait();
      rd(BCS_SEL_DIAG, 8'h7c);
      pins.first_output_fault <= 2'b00;
      pins.disable_pin <= 1'b0;
      pin_wait();
      rd(BCS_SEL_CFG, 8'h7e);
      rd(BCS_SEL_DIAG, 8'hff);
      // status flag mode holds reset values
      pins.output_supply_low <= 1'b1;
      pin_wait();
      wr(BCS_SEL_CFG, 8'h3e);
      rd(BCS_SEL_CFG, 8'hfa);
      rd(BCS_SEL_STAT, 8'hdf);
      pins.output_supply_low <= 1'b0;
      repeat (3) @(posedge clock_i);
      conclude();
   end
endmodule // testbench
